// File: src/clk_pm_pkg.sv
// Constants for CPU doze and module clock gating
package clk_pm_pkg;
  localparam logic [7:0] clock_divider_addr = 8'h00;
  localparam logic [7:0] module_disable_ctrl_1_addr = 8'h04;
  localparam logic [7:0] module_disable_ctrl_2_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0C;
  localparam int full_speed_on_interrupt_bit = 15;
  localparam int ratio_msb = 14;
  localparam int ratio_lsb = 12;
  localparam int cpu_slowdown_enable_bit = 11;
  localparam logic [15:0] clock_divider_reset = 16'h0000;
  localparam logic [15:0] clock_divider_mask = 16'hF800;
  localparam logic [15:0] module_disable_ctrl_1_reset = 16'h0000;
  localparam logic [15:0] module_disable_ctrl_2_reset = 16'h0000;
  // Implemented bits: timers 13..11, I2C 7, UART 5, SPI 3, ADC 0
  localparam logic [15:0] module_disable_ctrl_1_mask = 16'h38A9;
  // Capture 15,14,9,8, compare 1,0
  localparam logic [15:0] module_disable_ctrl_2_mask = 16'hC303;
  localparam int num_modules = 13;
  // Instruction-cycle period in system clocks
  localparam logic [7:0] instr_cycle_clocks = 8'h02;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
endpackage

// File: src/cpu_rate_divider.sv
// Counter that turns the doze ratio into a CPU clock enable
`timescale 1ns/1ns
module cpu_rate_divider
  import clk_pm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  cpu_rate_if.divider rate
);
  logic [6:0] count;
  logic [6:0] next_count;
  logic tick;
  logic next_tick;
  logic [6:0] limit;

  always_comb begin
    limit = 7'((8'h01 << rate.ratio) - 8'h01);
    next_count = count + 7'h01;
    next_tick = 1'b0;
    if (!rate.slow) begin
      // Full speed: enable every system clock
      next_count = 7'h00;
      next_tick = 1'b1;
    end else if (count >= limit) begin
      // One enable every 2**ratio system clocks
      next_count = 7'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 7'h00;
      // Full speed out of reset, so the enable must not dip
      tick <= 1'b1;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign rate.cpu_tick = tick;
endmodule

// File: src/cpu_rate_if.sv
// Carrier between the doze controller and the CPU rate divider
`timescale 1ns/1ns
interface cpu_rate_if;
  logic [2:0] ratio;
  logic slow;
  logic cpu_tick;
  modport ctrl (output ratio, output slow, input cpu_tick);
  modport divider (input ratio, input slow, output cpu_tick);
endinterface

// File: src/doze_gating.sv
// Doze control, module disable registers and AXI4-Lite slave
`timescale 1ns/1ns
// How it works
// - Doze slows CPU only, peripherals full rate
// - CPU enable stays aligned to system clock
// - Doze only while slowdown enable set
// - Three-bit ratio 1:1 to 1:128, default 1:1
// - Interrupt restores full speed if bit set
// - Disable bit stops module clock enable
// - Disabled module: writes dropped, reads invalid
// - Enabled only if present and bit clear
// - Disable/enable takes effect one instruction later
// - Timer disable bits 13,12,11 in register one
// - I2C 7, UART 5, SPI 3, ADC 0
// - Capture disables 15,14,9,8 in register two
// - Compare disables bits 1,0 in register two
module doze_gating
  import clk_pm_pkg::*;
#(
  parameter logic [12:0] module_present = 13'h1FFF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic interrupt_req,
  input wire logic [12:0] periph_sfr_write,
  input wire logic [12:0] periph_sfr_read,
  output logic cpu_clk_en,
  output logic [12:0] periph_clk_en,
  output logic [12:0] periph_sfr_wr_en,
  output logic [12:0] periph_sfr_rd_valid
);
  // Module order: 0 adc,1 spi,2 uart,3 i2c,4..6 timer a..c,
  // 7 capture 1,8 capture 2,9 capture 7,10 capture 8,
  // 11 compare 1,12 compare 2

  // ==========================================================
  // Registers and bus state
  // ==========================================================
  logic [15:0] clock_divider_reg;
  logic [15:0] module_disable_ctrl_1;
  logic [15:0] module_disable_ctrl_2;
  logic doze_active;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] next_clock_divider_reg;
  logic [15:0] next_module_disable_ctrl_1;
  logic [15:0] next_module_disable_ctrl_2;
  logic next_doze_active;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [15:0] wval;
  logic do_write;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_clock_divider_reg = clock_divider_reg;
    next_module_disable_ctrl_1 = module_disable_ctrl_1;
    next_module_disable_ctrl_2 = module_disable_ctrl_2;
    wval = 16'h0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = axi_okay;
      case (aw_addr)
        clock_divider_addr: begin
          wval = clock_divider_reg;
        end
        module_disable_ctrl_1_addr: begin
          wval = module_disable_ctrl_1;
        end
        module_disable_ctrl_2_addr: begin
          wval = module_disable_ctrl_2;
        end
        default: begin
          wval = 16'h0000;
        end
      endcase
      if (w_strb[0]) begin
        wval[7:0] = w_data[7:0];
      end
      if (w_strb[1]) begin
        wval[15:8] = w_data[15:8];
      end
      case (aw_addr)
        clock_divider_addr: begin
          next_clock_divider_reg = wval & clock_divider_mask;
        end
        module_disable_ctrl_1_addr: begin
          next_module_disable_ctrl_1 = wval & module_disable_ctrl_1_mask;
        end
        module_disable_ctrl_2_addr: begin
          next_module_disable_ctrl_2 = wval & module_disable_ctrl_2_mask;
        end
        status_addr: begin
          next_bresp = axi_okay;
        end
        default: begin
          next_bresp = axi_slverr;
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = axi_okay;
      case (s_axi_araddr)
        clock_divider_addr: begin
          next_rdata = {16'h0000, clock_divider_reg};
        end
        module_disable_ctrl_1_addr: begin
          next_rdata = {16'h0000, module_disable_ctrl_1};
        end
        module_disable_ctrl_2_addr: begin
          next_rdata = {16'h0000, module_disable_ctrl_2};
        end
        status_addr: begin
          next_rdata = {18'h00000, doze_active, periph_clk_en};
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = axi_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= axi_okay;
      clock_divider_reg <= clock_divider_reset;
      module_disable_ctrl_1 <= module_disable_ctrl_1_reset;
      module_disable_ctrl_2 <= module_disable_ctrl_2_reset;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      clock_divider_reg <= next_clock_divider_reg;
      module_disable_ctrl_1 <= next_module_disable_ctrl_1;
      module_disable_ctrl_2 <= next_module_disable_ctrl_2;
    end
  end

  // Ready flags are registered: accept when slot is free
  logic next_awready;
  logic next_wready;
  logic next_arready;
  always_comb begin
    next_awready = !next_aw_held && !(s_axi_awvalid && s_axi_awready);
    next_wready = !next_w_held && !(s_axi_wvalid && s_axi_wready);
    next_arready = !next_rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  // ==========================================================
  // Doze control
  // ==========================================================
  cpu_rate_if rate ();
  always_comb begin
    next_doze_active = doze_active;
    if (!clock_divider_reg[cpu_slowdown_enable_bit]) begin
      next_doze_active = 1'b0;
    end else if (interrupt_req &&
                 clock_divider_reg[full_speed_on_interrupt_bit]) begin
      next_doze_active = 1'b0;
    end else if (!doze_active && !interrupt_req) begin
      next_doze_active = 1'b1;
    end
  end
  // Doze lapses after an interrupt, when full speed on interrupt is set, until software clears the slowdown enable
  logic roi_hold;
  logic next_roi_hold;
  always_comb begin
    next_roi_hold = roi_hold;
    if (!clock_divider_reg[cpu_slowdown_enable_bit]) begin
      next_roi_hold = 1'b0;
    end else if (interrupt_req &&
                 clock_divider_reg[full_speed_on_interrupt_bit]) begin
      next_roi_hold = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      doze_active <= 1'b0;
      roi_hold <= 1'b0;
    end else begin
      doze_active <= next_doze_active && !next_roi_hold;
      roi_hold <= next_roi_hold;
    end
  end
  // Only CPU rate changes; peripherals keep the system clock.
  assign rate.slow = doze_active;
  assign rate.ratio = clock_divider_reg[ratio_msb:ratio_lsb];
  cpu_rate_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate(rate)
  );
  // Same clock, enable-based: both domains stay in step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= rate.cpu_tick;
    end
  end

  // ==========================================================
  // Module gating
  // ==========================================================
  logic [12:0] disable_bits;
  logic [7:0] icyc;
  logic [7:0] next_icyc;
  logic [12:0] stage;
  logic [12:0] next_stage;
  logic [12:0] next_en;
  always_comb begin
    disable_bits = {module_disable_ctrl_2[1], module_disable_ctrl_2[0],
                    module_disable_ctrl_2[15], module_disable_ctrl_2[14],
                    module_disable_ctrl_2[9], module_disable_ctrl_2[8],
                    module_disable_ctrl_1[13], module_disable_ctrl_1[12],
                    module_disable_ctrl_1[11], module_disable_ctrl_1[7],
                    module_disable_ctrl_1[5], module_disable_ctrl_1[3],
                    module_disable_ctrl_1[0]};
    next_icyc = (icyc >= instr_cycle_clocks - 8'h01) ? 8'h00 :
                icyc + 8'h01;
    next_stage = stage;
    next_en = periph_clk_en;
    if (icyc == instr_cycle_clocks - 8'h01) begin
      // Sampled on one instruction boundary, applied on the next
      next_stage = ~disable_bits & module_present;
      next_en = stage;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icyc <= 8'h00;
      stage <= module_present;
      periph_clk_en <= module_present;
      periph_sfr_wr_en <= 13'h0000;
      periph_sfr_rd_valid <= 13'h0000;
    end else begin
      icyc <= next_icyc;
      stage <= next_stage;
      periph_clk_en <= next_en;
      periph_sfr_wr_en <= periph_sfr_write & next_en;
      periph_sfr_rd_valid <= periph_sfr_read & next_en;
    end
  end
endmodule

// File: tb/doze_gating_chk.sv
// Checker for the doze and module clock gating block
`timescale 1ns/1ns
module doze_gating_chk
  import clk_pm_pkg::*;
#(
  parameter logic [12:0] module_present = 13'h1FFF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_clk_en,
  input wire logic [12:0] periph_clk_en,
  input wire logic [12:0] periph_sfr_write,
  input wire logic [12:0] periph_sfr_read,
  input wire logic [12:0] periph_sfr_wr_en,
  input wire logic [12:0] periph_sfr_rd_valid
);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  // Length of the current gap between CPU clock enables
  always_comb begin
    next_low_cnt = low_cnt + 8'h01;
    if (!aresetn || cpu_clk_en) begin
      next_low_cnt = 8'h00;
    end
  end
  always_ff @(posedge aclk) begin
    low_cnt <= next_low_cnt;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_full_speed:
    assert property (disable iff (1'b0)
      !aresetn |=> cpu_clk_en ##1 cpu_clk_en)
    else $error("cpu enable not high after reset");
  a_reset_all_on:
    assert property (disable iff (1'b0)
      !aresetn |=> periph_clk_en == module_present)
    else $error("module clocks not on after reset");
  a_absent_off:
    assert property ((periph_clk_en & ~module_present) == 13'h0000)
    else $error("absent module clocked");
  a_gap_bounded:
    assert property (low_cnt[7] == 1'b0)
    else $error("cpu enable gap above 127");
  a_write_needs_req:
    assert property ((periph_sfr_wr_en & ~$past(periph_sfr_write)) == 13'h0000)
    else $error("register write without request");
  a_read_needs_req:
    assert property ((periph_sfr_rd_valid & ~$past(periph_sfr_read)) == 0)
    else $error("register read valid without request");
  a_off_no_write:
    assert property ((periph_sfr_wr_en & ~periph_clk_en) == 13'h0000)
    else $error("write passed to disabled module");
  a_bresp_holds:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind doze_gating doze_gating_chk #(.module_present(module_present)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .periph_sfr_write(periph_sfr_write),
  .periph_sfr_read(periph_sfr_read), .periph_sfr_wr_en(periph_sfr_wr_en),
  .periph_sfr_rd_valid(periph_sfr_rd_valid)
);

// File: tb/periph_model.sv
// Peripheral side: register requests that change every cycle
`timescale 1ns/1ns
module periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [12:0] sfr_write,
  output logic [12:0] sfr_read
);
  // Walking pattern so every module sees both levels often
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfr_write <= 13'h0000;
    end else begin
      sfr_write <= {sfr_write[11:0], ~sfr_write[12]};
    end
  end
  assign sfr_read = ~sfr_write;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the doze and module clock gating block
`timescale 1ns/1ns
module tb_top
  import clk_pm_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, irq = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [12:0] wr, rd, clk_en, wr_en, rd_v, dis;
  logic cpu_en;
  logic [15:0] a, b;
  int seed, mismatches, comparisons, c;
  initial forever #2 aclk = ~aclk;
  doze_gating i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .interrupt_req(irq), .periph_sfr_write(wr),
    .periph_sfr_read(rd), .cpu_clk_en(cpu_en), .periph_clk_en(clk_en),
    .periph_sfr_wr_en(wr_en), .periph_sfr_rd_valid(rd_v));
  periph_model i_periph (.aclk(aclk), .aresetn(aresetn), .sfr_write(wr),
    .sfr_read(rd));
  // ==========================================
  // Checking and closing
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [12:0] dis_of(logic [15:0] x, logic [15:0] y);
    return {y[1], y[0], y[15], y[14], y[9], y[8], x[13], x[12], x[11],
      x[7], x[5], x[3], x[0]};
  endfunction
  // ==========================================
  // Bus cycles
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
    int n;
    @(posedge aclk);
    awaddr <= ad; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 0;
    if (n >= 200) begin mismatches++; wrap_up(); end
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    int n;
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    r = rresp; d = rdata;
    rready <= 0;
    if (n >= 200) begin mismatches++; wrap_up(); end
  endtask
  task automatic count_en(input int n);
    c = 0;
    repeat (n) begin
      @(posedge aclk);
      if (cpu_en === 1'b1) c++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed = 51059;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axi_rd(clock_divider_addr);
    chk(d, 0);
    axi_rd(module_disable_ctrl_1_addr);
    chk(d, 0);
    chk(32'(clk_en), 32'h1FFF);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      b = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      axi_wr(module_disable_ctrl_1_addr, {16'h0000, a}); chk(r, axi_okay);
      axi_wr(module_disable_ctrl_2_addr, {16'h0000, b});
      axi_rd(module_disable_ctrl_1_addr);
      chk(d, 32'(a & 16'h38A9));
      axi_rd(module_disable_ctrl_2_addr);
      chk(d, 32'(b & 16'hC303));
      dis = dis_of(a, b);
      repeat (6) @(posedge aclk);
      chk(32'(clk_en), 32'(dis ^ 13'h1FFF));
      chk(32'(wr_en & dis), 0);
      // Read request is the inverse of write, so one of them passes
      chk(32'(wr_en | rd_v), 32'(dis ^ 13'h1FFF));
      axi_rd(status_addr);
      chk(32'(d[12:0]), 32'(dis ^ 13'h1FFF));
    end
    axi_rd(8'h10); chk(32'(r), 32'(axi_slverr)); chk(d, 0);
    axi_wr(8'h14, 32'hFFFF_FFFF); chk(32'(r), 32'(axi_slverr));
    for (int k = 0; k < 8; k++) begin
      axi_wr(clock_divider_addr, {17'h0, 3'(k), 12'h000});
      repeat (4) @(posedge aclk);
      count_en(256);
      chk(c, 256);
      axi_rd(status_addr);
      chk(32'(d[13]), 0);
      axi_wr(clock_divider_addr, {17'h0, 3'(k), 12'h800});
      repeat (4) @(posedge aclk);
      count_en(256);
      chk(c, 256 >> k);
      chk(32'(clk_en), 32'(dis ^ 13'h1FFF));
      axi_rd(status_addr);
      chk(32'(d[13]), 1);
      axi_rd(clock_divider_addr);
      chk(d, {17'h0, 3'(k), 12'h800});
    end
    for (int k = 0; k < 2; k++) begin
      axi_wr(clock_divider_addr, 0);
      axi_wr(clock_divider_addr, {16'h0, 1'(k), 15'h3800});
      repeat (4) @(posedge aclk);
      irq <= 1;
      repeat (4) @(posedge aclk);
      count_en(64);
      chk(c, k ? 64 : 8);
      axi_rd(status_addr);
      chk(32'(d[13]), 32'(k == 0));
      irq <= 0;
    end
    wrap_up();
  end
endmodule
